/* File: rfpc_regs.vh */
// Constants for the receiver fault and pin control block.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef RFPC_REGS_VH
`define RFPC_REGS_VH

// ----------------------------------------------------------------------
// Serial target address and register offsets
// ----------------------------------------------------------------------
`define RFPC_TARGET_ADDR 7'h68
`define RFPC_OFS_RAW_HI 8'hD4
`define RFPC_OFS_RAW_LO 8'hD5
`define RFPC_OFS_MSKD_HI 8'hD6
`define RFPC_OFS_MSKD_LO 8'hD7
`define RFPC_OFS_TEMP_A 8'hE0
`define RFPC_OFS_TEMP_B 8'hE1

// ----------------------------------------------------------------------
// Fault bit positions in the low fault byte
// ----------------------------------------------------------------------
`define RFPC_BIT_SHUTDOWN 0
`define RFPC_BIT_END_CHARGE 2
`define RFPC_BIT_DIE_HOT 5
`define RFPC_BIT_TEMP_A 6
`define RFPC_BIT_TEMP_B 7

// ----------------------------------------------------------------------
// End-of-power packet reason codes, reset values and serial bit counts
// ----------------------------------------------------------------------
`define RFPC_REASON_END_CHARGE 8'h01
`define RFPC_REASON_OVER_TEMP 8'h02
`define RFPC_REASON_REMOTE_TEMP 8'h03
`define RFPC_REASON_NONE 8'h00
`define RFPC_BYTE_ZERO 8'h00
`define RFPC_BITS_PER_BYTE 4'h8
`define RFPC_LAST_BIT 4'h7

`endif

/* File: rfpc_sync.v */
// Two-stage level synchroniser, one lane per bit.
// Assumes the inputs may change at any time relative to the clock.
`timescale 1ns/1ps

module rfpc_sync
#(
	parameter WIDTH = 2
)
(
	input wire clk, // Block clock.
	input wire rst, // Synchronous reset, active high.
	input wire [WIDTH-1:0] async_in, // Pin levels to be synchronised.
	output reg [WIDTH-1:0] sync_out // Synchronised levels.
);

reg [WIDTH-1:0] meta;

// First stage is read only by the second stage to keep metastability contained.
always @(posedge clk)
begin
	if (rst)
	begin
		meta <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end
	else
	begin
		meta <= async_in;
		sync_out <= meta;
	end
end

endmodule // rfpc_sync

/* File: rfpc_fault_ctrl.v */
// Fault, pin and status logic of a wireless power receiver.
// Assumes the link modulator takes end-of-power packets by valid/ready and
// that the serial clock and data pins are sampled synchronously to CLOCK.
//
// Overview of operation
// R1 - Shutdown pin high: packet, shut down, output high-Z.
// R2 - Shutdown pin low: normal operation.
// R3 - Activity flag pulled low during power transfer.
// R4 - Interrupt signals any of the five fault sources.
// R5 - No fault: interrupt stays released, pulled high.
// R6 - Interrupt cause readable over serial bus.
// R7 - End-of-charge high issues end-of-power packet.
// R8 - Transmitter waits five minutes before pinging again.
// R9 - Both thermistor readings digitised, readable by host.
// R10 - Reading equals voltage over 1.8 V times 255.
// R11 - Packet reason: 01 charge, 02 heat/shutdown, 03 thermistor.
// R12 - Raw fault bit follows condition, ignoring mask.
// R13 - Masked bit and packet need enable bit set.
// R14 - Serial target answers at address 0x68.
// R15 - Shutdown and end-of-charge pins synchronised first.
`timescale 1ns/1ps
`include "rfpc_regs.vh"

module rfpc_fault_ctrl
(
	input wire CLOCK, // Block clock, 100 MHz.
	input wire RESET, // Synchronous reset, active high.
	input wire SHUTDOWN_N_PIN, // Active-low enable pin; high requests shutdown.
	input wire END_CHARGE_PIN, // End-of-charge pin, active high.
	input wire DIE_HOT, // Die temperature at its limit, active high.
	input wire LINK_POWER_PHASE, // Link established and power being transferred.
	input wire [7:0] REMOTE_TEMP_IN_A, // Converter code of thermistor A.
	input wire REMOTE_TEMP_A_VALID, // One-cycle strobe for a new code A.
	input wire [7:0] REMOTE_TEMP_IN_B, // Converter code of thermistor B.
	input wire REMOTE_TEMP_B_VALID, // One-cycle strobe for a new code B.
	input wire [7:0] TEMP_A_LIMIT, // Trip level for thermistor A.
	input wire [7:0] TEMP_B_LIMIT, // Trip level for thermistor B.
	input wire [7:0] FAULT_ENABLE, // Enable bits for masked faults.
	input wire END_POWER_PACKET_READY, // Modulator takes the packet.
	input wire SCL_IN, // Serial clock level.
	input wire SDA_IN, // Serial data level.
	output reg SDA_OE, // High while pulling serial data low.
	output reg SDA_OUT, // Serial data drive value, always low.
	output reg END_POWER_PACKET_VALID, // Packet request pending.
	output reg [7:0] END_POWER_PACKET_CODE, // Packet reason code.
	output reg RECEIVER_OFF, // Receiver shut down.
	output reg OUTPUT_HIGH_Z, // Regulated output in high impedance.
	output reg TRANSFER_ACTIVE_FLAG_N_OE, // High while pulling the activity flag low.
	output reg TRANSFER_ACTIVE_FLAG_N_OUT, // Activity flag drive value, always low.
	output reg FAULT_INT_N_OE, // High while pulling the interrupt low.
	output reg FAULT_INT_N_OUT, // Interrupt drive value, always low.
	output reg [7:0] FAULT_RAW_FLAGS // Present fault conditions.
);

// ----------------------------------------------------------------------
// Serial target states
// ----------------------------------------------------------------------
localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_ADDR = 7'h02;
localparam [6:0] ST_ACK_ADDR = 7'h04;
localparam [6:0] ST_WRITE = 7'h08;
localparam [6:0] ST_ACK_WRITE = 7'h10;
localparam [6:0] ST_READ = 7'h20;
localparam [6:0] ST_HOST_ACK = 7'h40;

wire [1:0] pin_sync;
reg [7:0] masked;
reg [7:0] masked_q;
reg [7:0] pending;
reg [7:0] sent_sel;
reg [7:0] next_sel;
reg [7:0] next_code;
reg [7:0] temp_a;
reg [7:0] temp_b;
reg [6:0] state;
reg [3:0] bit_cnt;
reg [7:0] shreg;
reg [7:0] ptr;
reg rd_mode;
reg host_ack;
reg scl_q;
reg sda_q;
wire scl_rise;
wire scl_fall;
wire start_cond;
wire stop_cond;
wire [7:0] fault_now;
wire [7:0] rd_byte;
integer i;

// Maps the byte pointer onto the readable status; unmapped offsets read zero.
function [7:0] rfpc_read;
	input [7:0] ofs;
	input [7:0] raw;
	input [7:0] msk;
	input [7:0] ta;
	input [7:0] tb;
	begin
		if (ofs == `RFPC_OFS_RAW_LO)
			rfpc_read = raw; // [R6]
		else if (ofs == `RFPC_OFS_MSKD_LO)
			rfpc_read = msk;
		else if (ofs == `RFPC_OFS_TEMP_A)
			rfpc_read = ta; // [R9]
		else if (ofs == `RFPC_OFS_TEMP_B)
			rfpc_read = tb; // [R9]
		else
			rfpc_read = `RFPC_BYTE_ZERO;
	end
endfunction

// Reason code for a one-hot fault selection.
function [7:0] rfpc_reason;
	input [7:0] sel;
	begin
		if (sel[`RFPC_BIT_END_CHARGE])
			rfpc_reason = `RFPC_REASON_END_CHARGE; // [R11]
		else if (sel[`RFPC_BIT_SHUTDOWN] | sel[`RFPC_BIT_DIE_HOT])
			rfpc_reason = `RFPC_REASON_OVER_TEMP; // [R11]
		else if (sel[`RFPC_BIT_TEMP_A] | sel[`RFPC_BIT_TEMP_B])
			rfpc_reason = `RFPC_REASON_REMOTE_TEMP; // [R11]
		else
			rfpc_reason = `RFPC_REASON_NONE;
	end
endfunction

// ----------------------------------------------------------------------
// Pin synchronisation
// ----------------------------------------------------------------------
// Both control pins arrive from outside the clock domain.
rfpc_sync #(.WIDTH(2)) u_sync
(
	.clk(CLOCK),
	.rst(RESET),
	.async_in({END_CHARGE_PIN, SHUTDOWN_N_PIN}),
	.sync_out(pin_sync)
); // [R15]

// ----------------------------------------------------------------------
// Fault detection
// ----------------------------------------------------------------------
// Present conditions; the thermistor trip compares the held reading to its limit.
assign fault_now[`RFPC_BIT_SHUTDOWN] = pin_sync[0];
assign fault_now[1] = 1'b0;
assign fault_now[`RFPC_BIT_END_CHARGE] = pin_sync[1];
assign fault_now[4:3] = 2'b00;
assign fault_now[`RFPC_BIT_DIE_HOT] = DIE_HOT;
assign fault_now[`RFPC_BIT_TEMP_A] = temp_a > TEMP_A_LIMIT;
assign fault_now[`RFPC_BIT_TEMP_B] = temp_b > TEMP_B_LIMIT;

// Raw flags follow conditions; masked flags also need the enable bit.
always @(posedge CLOCK)
begin
	if (RESET)
	begin
		FAULT_RAW_FLAGS <= `RFPC_BYTE_ZERO;
		masked <= `RFPC_BYTE_ZERO;
		masked_q <= `RFPC_BYTE_ZERO;
		temp_a <= `RFPC_BYTE_ZERO;
		temp_b <= `RFPC_BYTE_ZERO;
	end
	else
	begin
		FAULT_RAW_FLAGS <= fault_now; // [R12]
		masked <= fault_now & FAULT_ENABLE; // [R13]
		masked_q <= masked;
		// The converter already scales V/1.8 V to 0..255, so codes are kept as given.
		if (REMOTE_TEMP_A_VALID)
			temp_a <= REMOTE_TEMP_IN_A; // [R9] [R10]
		if (REMOTE_TEMP_B_VALID)
			temp_b <= REMOTE_TEMP_IN_B; // [R9] [R10]
	end
end

// ----------------------------------------------------------------------
// Pin outputs
// ----------------------------------------------------------------------
// Open-drain pins only ever drive low, so the drive values stay zero.
always @(posedge CLOCK)
begin
	if (RESET)
	begin
		RECEIVER_OFF <= 1'b0;
		OUTPUT_HIGH_Z <= 1'b0;
		TRANSFER_ACTIVE_FLAG_N_OE <= 1'b0;
		TRANSFER_ACTIVE_FLAG_N_OUT <= 1'b0;
		FAULT_INT_N_OE <= 1'b0;
		FAULT_INT_N_OUT <= 1'b0;
		SDA_OUT <= 1'b0;
	end
	else
	begin
		RECEIVER_OFF <= pin_sync[0]; // [R1] [R2]
		OUTPUT_HIGH_Z <= pin_sync[0]; // [R1] [R2]
		TRANSFER_ACTIVE_FLAG_N_OE <= LINK_POWER_PHASE & ~pin_sync[0]; // [R3]
		TRANSFER_ACTIVE_FLAG_N_OUT <= 1'b0;
		FAULT_INT_N_OE <= |fault_now; // [R4] [R5]
		FAULT_INT_N_OUT <= 1'b0;
		SDA_OUT <= 1'b0;
	end
end

// ----------------------------------------------------------------------
// End-of-power packet requests
// ----------------------------------------------------------------------
// Lowest pending bit goes first; a new rising edge always beats the clear.
always @*
begin
	next_sel = `RFPC_BYTE_ZERO;
	for (i = 7; i >= 0; i = i - 1)
	begin
		if (pending[i])
		begin
			next_sel = `RFPC_BYTE_ZERO;
			next_sel[i] = 1'b1;
		end
	end
	next_code = rfpc_reason(next_sel);
end

always @(posedge CLOCK)
begin
	if (RESET)
	begin
		pending <= `RFPC_BYTE_ZERO;
		sent_sel <= `RFPC_BYTE_ZERO;
		END_POWER_PACKET_VALID <= 1'b0;
		END_POWER_PACKET_CODE <= `RFPC_REASON_NONE;
	end
	else
	begin
		if (END_POWER_PACKET_VALID & END_POWER_PACKET_READY)
		begin
			END_POWER_PACKET_VALID <= 1'b0;
			pending <= (pending & ~sent_sel) | (masked & ~masked_q); // [R1] [R7] [R13]
		end
		else
		begin
			pending <= pending | (masked & ~masked_q); // [R1] [R7] [R13]
			if (~END_POWER_PACKET_VALID & (|pending))
			begin
				END_POWER_PACKET_VALID <= 1'b1;
				END_POWER_PACKET_CODE <= next_code; // [R11]
				sent_sel <= next_sel;
			end
		end
	end
end

// ----------------------------------------------------------------------
// Serial target
// ----------------------------------------------------------------------
assign scl_rise = SCL_IN & ~scl_q;
assign scl_fall = ~SCL_IN & scl_q;
assign start_cond = SCL_IN & scl_q & sda_q & ~SDA_IN;
assign stop_cond = SCL_IN & scl_q & ~sda_q & SDA_IN;
assign rd_byte = rfpc_read(ptr, FAULT_RAW_FLAGS, masked, temp_a, temp_b);

// Byte pointer is set by a write; reads stream from it with auto-increment.
always @(posedge CLOCK)
begin
	if (RESET)
	begin
		scl_q <= 1'b1;
		sda_q <= 1'b1;
		state <= ST_IDLE;
		bit_cnt <= 4'h0;
		shreg <= `RFPC_BYTE_ZERO;
		ptr <= `RFPC_BYTE_ZERO;
		rd_mode <= 1'b0;
		host_ack <= 1'b0;
		SDA_OE <= 1'b0;
	end
	else
	begin
		scl_q <= SCL_IN;
		sda_q <= SDA_IN;
		if (start_cond)
		begin
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
			SDA_OE <= 1'b0;
		end
		else if (stop_cond)
		begin
			state <= ST_IDLE;
			SDA_OE <= 1'b0;
		end
		else
		begin
			case (state)
				ST_ADDR, ST_WRITE:
				begin
					if (scl_rise & (bit_cnt != `RFPC_BITS_PER_BYTE))
					begin
						shreg <= {shreg[6:0], SDA_IN};
						bit_cnt <= bit_cnt + 4'h1;
					end
					else if (scl_fall & (bit_cnt == `RFPC_BITS_PER_BYTE))
					begin
						bit_cnt <= 4'h0;
						if (state == ST_WRITE)
						begin
							ptr <= shreg;
							SDA_OE <= 1'b1;
							state <= ST_ACK_WRITE;
						end
						else if (shreg[7:1] == `RFPC_TARGET_ADDR) // [R14]
						begin
							rd_mode <= shreg[0];
							SDA_OE <= 1'b1;
							state <= ST_ACK_ADDR;
						end
						else
							state <= ST_IDLE;
					end
				end
				ST_ACK_ADDR, ST_ACK_WRITE:
				begin
					if (scl_fall)
					begin
						if (rd_mode & (state == ST_ACK_ADDR))
						begin
							shreg <= rd_byte;
							SDA_OE <= ~rd_byte[7];
							state <= ST_READ;
						end
						else
						begin
							SDA_OE <= 1'b0;
							state <= ST_WRITE;
						end
					end
				end
				ST_READ:
				begin
					if (scl_fall)
					begin
						if (bit_cnt == `RFPC_LAST_BIT)
						begin
							bit_cnt <= 4'h0;
							SDA_OE <= 1'b0;
							ptr <= ptr + 8'h01;
							state <= ST_HOST_ACK;
						end
						else
						begin
							bit_cnt <= bit_cnt + 4'h1;
							shreg <= {shreg[6:0], 1'b0};
							SDA_OE <= ~shreg[6];
						end
					end
				end
				ST_HOST_ACK:
				begin
					// A host not-acknowledge ends the read burst.
					if (scl_rise)
						host_ack <= ~SDA_IN;
					else if (scl_fall)
					begin
						if (host_ack)
						begin
							shreg <= rd_byte;
							SDA_OE <= ~rd_byte[7];
							state <= ST_READ;
						end
						else
							state <= ST_IDLE;
					end
				end
				default:
				begin
					SDA_OE <= 1'b0;
					state <= ST_IDLE;
				end
			endcase
		end
	end
end

endmodule // rfpc_fault_ctrl

/* File: rfpc_assertions.sv */
// Port-level checks of the receiver fault and pin control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module rfpc_assertions
(
	input wire CLOCK, // Block clock.
	input wire RESET, // Synchronous reset.
	input wire SHUTDOWN_N_PIN, // Shutdown request pin.
	input wire END_CHARGE_PIN, // End-of-charge pin.
	input wire DIE_HOT, // Die at its limit.
	input wire LINK_POWER_PHASE, // Power flowing.
	input wire [7:0] REMOTE_TEMP_IN_A, // Code of thermistor A.
	input wire REMOTE_TEMP_A_VALID, // Strobe of code A.
	input wire [7:0] TEMP_A_LIMIT, // Trip level A.
	input wire END_POWER_PACKET_READY, // Packet taken.
	input wire END_POWER_PACKET_VALID, // Packet pending.
	input wire [7:0] END_POWER_PACKET_CODE, // Packet reason.
	input wire RECEIVER_OFF, // Receiver shut down.
	input wire OUTPUT_HIGH_Z, // Output released.
	input wire TRANSFER_ACTIVE_FLAG_N_OE, // Activity flag pulled.
	input wire FAULT_INT_N_OE, // Interrupt pulled.
	input wire FAULT_INT_N_OUT, // Interrupt drive value.
	input wire [7:0] FAULT_RAW_FLAGS // Present faults.
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);

	// ----------------------------------------------------------------
	// Pins and faults
	// ----------------------------------------------------------------
	// Four samples cover two synchroniser stages plus the output stage.
	chk_shutdown_acts: assert property (
		SHUTDOWN_N_PIN [*4] |-> RECEIVER_OFF && OUTPUT_HIGH_Z && FAULT_RAW_FLAGS[0])
		else $error("shutdown pin not acted on");
	chk_normal_run: assert property (
		!SHUTDOWN_N_PIN [*4] |-> !RECEIVER_OFF && !OUTPUT_HIGH_Z)
		else $error("receiver off with pin low");
	chk_charge_raw: assert property (
		END_CHARGE_PIN [*4] |-> FAULT_RAW_FLAGS[2])
		else $error("end-of-charge flag missing");
	chk_die_raw: assert property (
		DIE_HOT |=> FAULT_RAW_FLAGS[5])
		else $error("die flag missing");
	chk_temp_trip: assert property (
		REMOTE_TEMP_A_VALID && REMOTE_TEMP_IN_A > TEMP_A_LIMIT |=> ##1 FAULT_RAW_FLAGS[6])
		else $error("thermistor trip missing");
	// The interrupt must mirror the fault byte, so it is idle with no fault.
	chk_int_cause: assert property (
		FAULT_INT_N_OE == (FAULT_RAW_FLAGS != 8'h00) && !FAULT_INT_N_OUT)
		else $error("interrupt disagrees with faults");
	chk_flag_link: assert property (
		!LINK_POWER_PHASE |=> !TRANSFER_ACTIVE_FLAG_N_OE)
		else $error("activity flag without link");

	// ----------------------------------------------------------------
	// End-of-power packet handshake
	// ----------------------------------------------------------------
	chk_pkt_hold: assert property (
		END_POWER_PACKET_VALID && !END_POWER_PACKET_READY
		|=> END_POWER_PACKET_VALID && $stable(END_POWER_PACKET_CODE))
		else $error("packet dropped or changed");
	chk_pkt_drop: assert property (
		END_POWER_PACKET_VALID && END_POWER_PACKET_READY |=> !END_POWER_PACKET_VALID)
		else $error("packet repeated");
	chk_pkt_code: assert property (
		END_POWER_PACKET_VALID |-> END_POWER_PACKET_CODE inside {8'h01, 8'h02, 8'h03})
		else $error("bad packet reason");
endmodule // rfpc_assertions

bind rfpc_fault_ctrl rfpc_assertions i_chk (.CLOCK, .RESET, .SHUTDOWN_N_PIN, .END_CHARGE_PIN,
	.DIE_HOT, .LINK_POWER_PHASE, .REMOTE_TEMP_IN_A, .REMOTE_TEMP_A_VALID, .TEMP_A_LIMIT,
	.END_POWER_PACKET_READY, .END_POWER_PACKET_VALID, .END_POWER_PACKET_CODE,
	.RECEIVER_OFF, .OUTPUT_HIGH_Z, .TRANSFER_ACTIVE_FLAG_N_OE, .FAULT_INT_N_OE,
	.FAULT_INT_N_OUT, .FAULT_RAW_FLAGS);

/* File: rfpc_modulator.sv */
// Transmitter side model: takes end-of-power packets and drops the link.
// Assumes the packet request is held until taken, as the block promises.
`timescale 1ns/1ps

module rfpc_modulator
#(
	parameter STANDBY = 20
)
(
	input wire clk, // Block clock.
	input wire rst, // Reset, active high.
	input wire slow, // Delay the take by six cycles.
	input wire valid, // Packet pending.
	input wire [7:0] code, // Packet reason.
	output reg ready, // Packet taken at this edge.
	output reg link, // Link up, power flowing.
	output reg [7:0] got_code, // Last reason taken.
	output integer got_n // Packets taken.
);
	integer cnt;
	integer idle;

	// Ready changes off the rising edge; a slow take tests the hold.
	always @(negedge clk)
		if (rst || !valid)
		begin
			cnt <= 0;
			ready <= 1'b0;
		end
		else if (cnt >= (slow ? 6 : 0))
			ready <= 1'b1;
		else
			cnt <= cnt + 1;

	// Standby stands in for the long wait before pinging resumes.
	always @(posedge clk)
		if (rst)
		begin
			link <= 1'b1;
			idle <= 0;
			got_n <= 0;
			got_code <= 8'h00;
		end
		else if (valid && ready)
		begin
			got_code <= code;
			got_n <= got_n + 1;
			link <= 1'b0;
			idle <= STANDBY;
		end
		else if (idle > 0)
		begin
			idle <= idle - 1;
			link <= (idle == 1);
		end
endmodule // rfpc_modulator

/* File: tb_rx_fault_pin_control.sv */
// Self-checking bench for the receiver fault and pin control block.
// Assumes the transmitter model answers the end-of-power packets.
`timescale 1ns/1ps

module tb_rx_fault_pin_control;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg sd = 1'b0;
	reg eoc = 1'b0;
	reg hot = 1'b0;
	reg [7:0] ca = 8'h00;
	reg [7:0] cb = 8'h00;
	reg va = 1'b0;
	reg vb = 1'b0;
	reg [7:0] lim = 8'h00;
	reg [7:0] fen = 8'h00;
	reg slow = 1'b0;
	reg scl = 1'b1;
	reg sda = 1'b1;
	wire ready, link, valid, off, hiz, act_oe, int_oe;
	wire sda_oe, sda_out, act_out;
	wire sda_bus;
	wire [7:0] code, raw, got_code;
	integer got_n;
	integer n_mismatch = 0;
	integer check_count = 0;

	always #5 clk = ~clk;

	// Open-drain serial data: the target can only pull the host's level low.
	assign sda_bus = sda & ~(sda_oe & ~sda_out);

	rfpc_fault_ctrl i_dut (.CLOCK(clk), .RESET(rst), .SHUTDOWN_N_PIN(sd),
		.END_CHARGE_PIN(eoc), .DIE_HOT(hot), .LINK_POWER_PHASE(link),
		.REMOTE_TEMP_IN_A(ca), .REMOTE_TEMP_A_VALID(va), .REMOTE_TEMP_IN_B(cb),
		.REMOTE_TEMP_B_VALID(vb), .TEMP_A_LIMIT(lim), .TEMP_B_LIMIT(lim),
		.FAULT_ENABLE(fen), .END_POWER_PACKET_READY(ready), .SCL_IN(scl), .SDA_IN(sda_bus),
		.SDA_OE(sda_oe), .SDA_OUT(sda_out), .END_POWER_PACKET_VALID(valid),
		.END_POWER_PACKET_CODE(code),
		.RECEIVER_OFF(off), .OUTPUT_HIGH_Z(hiz), .TRANSFER_ACTIVE_FLAG_N_OE(act_oe),
		.TRANSFER_ACTIVE_FLAG_N_OUT(act_out), .FAULT_INT_N_OE(int_oe), .FAULT_INT_N_OUT(),
		.FAULT_RAW_FLAGS(raw));

	rfpc_modulator #(.STANDBY(20)) i_tx (.clk(clk), .rst(rst), .slow(slow), .valid(valid),
		.code(code), .ready(ready), .link(link), .got_code(got_code), .got_n(got_n));

	task check(input [7:0] seen, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp)
			begin
				n_mismatch = n_mismatch + 1;
				$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task step(input integer n);
		repeat (n) @(negedge clk);
	endtask

	// Bounded wait for one packet, then its reason.
	task wait_pkt(input [7:0] exp);
		integer n0;
		integer i;
		begin
			n0 = got_n;
			for (i = 0; i < 40 && got_n == n0; i = i + 1)
				step(1);
			check({7'h00, got_n != n0}, 8'h01);
			check(got_code, exp);
		end
	endtask

	// A held or disabled fault must not send a packet.
	task no_pkt;
		integer n0;
		begin
			n0 = got_n;
			step(12);
			check({7'h00, got_n != n0}, 8'h00);
		end
	endtask

	task t_shutdown;
		begin
			fen = 8'hE5;
			sd = 1'b1;
			step(2);
			check(raw, 8'h00);
			step(1);
			check(raw, 8'h01);
			check({4'h0, off, hiz, int_oe, act_oe}, 8'h0E);
			wait_pkt(8'h02);
			sd = 1'b0;
			step(3);
			check({5'h00, off, hiz, int_oe}, 8'h00);
			check(raw, 8'h00);
			step(24);
		end
	endtask

	task t_charge;
		begin
			slow = 1'b1;
			fen = 8'h04;
			eoc = 1'b1;
			step(3);
			check({raw[7:1], int_oe}, 8'h05);
			wait_pkt(8'h01);
			step(2);
			check({7'h00, act_oe}, 8'h00);
			no_pkt();
			eoc = 1'b0;
			slow = 1'b0;
			step(24);
			check({7'h00, act_oe}, 8'h01);
		end
	endtask

	task t_masked;
		begin
			fen = 8'h00;
			hot = 1'b1;
			step(1);
			check(raw, 8'h20);
			check({7'h00, int_oe}, 8'h01);
			no_pkt();
			hot = 1'b0;
			step(1);
			check(raw, 8'h00);
		end
	endtask

	// Codes are the bias current times the resistance over a 1.8 V full scale.
	task t_remote;
		begin
			fen = 8'hC0;
			lim = 10000 * 255 / 18000;
			ca = 11000 * 255 / 18000;
			cb = lim;
			va = 1'b1;
			vb = 1'b1;
			step(1);
			va = 1'b0;
			vb = 1'b0;
			step(1);
			check(raw, 8'h40);
			wait_pkt(8'h03);
			cb = 8'hFF;
			vb = 1'b1;
			step(1);
			vb = 1'b0;
			step(1);
			check(raw, 8'hC0);
			wait_pkt(8'h03);
		end
	endtask

	// One serial bit: data set while the clock is low, sampled at the end of the high phase.
	task i2c_bit(input b, output r);
		begin
			sda = b;
			step(4);
			scl = 1'b1;
			step(4);
			r = sda_bus;
			scl = 1'b0;
		end
	endtask

	// Start, or a repeated start when the clock is already low.
	task i2c_start;
		begin
			sda = 1'b1;
			step(4);
			scl = 1'b1;
			step(4);
			sda = 1'b0;
			step(4);
			scl = 1'b0;
		end
	endtask

	task i2c_stop;
		begin
			sda = 1'b0;
			step(4);
			scl = 1'b1;
			step(4);
			sda = 1'b1;
			step(4);
		end
	endtask

	// A byte MSB first, then the ninth bit; a read sends all ones so the target can drive.
	task i2c_byte(input [7:0] tx, input nine, output [7:0] rx, output ack);
		integer k;
		reg b;
		begin
			for (k = 7; k >= 0; k = k - 1)
			begin
				i2c_bit(tx[k], b);
				rx[k] = b;
			end
			i2c_bit(nine, ack);
		end
	endtask

	// Pointer write, repeated start, then two bytes read with the last one refused.
	task rd_pair(input [7:0] ofs, output [7:0] d0, output [7:0] d1, output [2:0] acks);
		reg [7:0] unused;
		reg nack;
		begin
			i2c_start();
			i2c_byte({7'h68, 1'b0}, 1'b1, unused, acks[2]);
			i2c_byte(ofs, 1'b1, unused, acks[1]);
			i2c_start();
			i2c_byte({7'h68, 1'b1}, 1'b1, unused, acks[0]);
			i2c_byte(8'hFF, 1'b0, d0, nack);
			i2c_byte(8'hFF, 1'b1, d1, nack);
			i2c_stop();
		end
	endtask

	// Status and thermistor codes read back by the host; a foreign address is ignored.
	task t_serial;
		reg [7:0] d0;
		reg [7:0] d1;
		reg [2:0] acks;
		reg [7:0] unused;
		reg ack;
		begin
			rd_pair(8'hD5, d0, d1, acks);
			check({5'h00, acks}, 8'h00);
			check(d0, 8'hC0);
			check(d1, 8'h00);
			rd_pair(8'hD7, d0, d1, acks);
			check(d0, 8'hC0);
			rd_pair(8'hE0, d0, d1, acks);
			check(d0, ca);
			check(d1, cb);
			i2c_start();
			i2c_byte({7'h69, 1'b1}, 1'b1, unused, ack);
			i2c_stop();
			check({7'h00, ack}, 8'h01);
			check({6'h00, sda_out, act_out}, 8'h00);
		end
	endtask

	task close_out;
		begin
			if (n_mismatch == 0 && check_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	initial
	begin
		step(5);
		rst = 1'b0;
		step(1);
		check({valid, off, hiz, int_oe, raw[3:0]}, 8'h00);
		t_shutdown();
		t_charge();
		t_masked();
		t_remote();
		t_serial();
		close_out();
	end

	initial
	begin
		#50000;
		n_mismatch = n_mismatch + 1;
		close_out();
	end
endmodule // tb_rx_fault_pin_control
